// ===== rtl/scr_map.vh
// Register map, field positions, reset values and timing constants
// for the sensor control register bank.
// Assumes inclusion by bare name from the design files.
`ifndef SCR_MAP_VH
`define SCR_MAP_VH

`define SCR_ADDR_ILLUM_CTRL   8'h40
`define SCR_ADDR_MOTION_CFG   8'h41
`define SCR_ADDR_BURST_START  8'h42
`define SCR_ADDR_BURST_END    8'h44
`define SCR_ADDR_REST_CFG     8'h45
`define SCR_ADDR_BURST_PORT   8'h63

`define SCR_ILLUM_OFF_BIT     3
`define SCR_PIN_POL_BIT       7
`define SCR_PIN_EDGE_BIT      6
`define SCR_REST_HI           7
`define SCR_REST_LO           6
`define SCR_WRITE_FLAG_BIT    7

`define SCR_RST_ILLUM_OFF     1'b0
`define SCR_RST_PIN_POL       1'b0
`define SCR_RST_PIN_EDGE      1'b1
`define SCR_RST_BURST_START   8'h03
`define SCR_RST_BURST_END     8'h09
`define SCR_RST_REST_FORCE    2'h0
`define SCR_RST_BURST_PORT    8'h00

`define SCR_CLK_MHZ           200
`define SCR_PULSE_NS          380
`define SCR_PULSE_CYC         ((`SCR_PULSE_NS * `SCR_CLK_MHZ) / 1000)
`define SCR_IDLE_NS           20000
`define SCR_IDLE_CYC          ((`SCR_IDLE_NS * `SCR_CLK_MHZ) / 1000)

`endif

// ===== rtl/scr_fifo.v
// Small first-in first-out buffer with valid/ready on both sides.
// Assumes one clock domain and a synchronous flush from the owner.
`timescale 1ns/100ps
module scr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 2,
    parameter AW    = 1
) (
    input  wire             i_clk,
    input  wire             i_rst,
    input  wire             i_flush,
    input  wire             i_valid,
    output wire             o_ready,
    input  wire [WIDTH-1:0] i_data,
    output wire             o_valid,
    input  wire             i_ready,
    output wire [WIDTH-1:0] o_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;
    integer         k;

    assign o_ready = (count_reg < DEPTH);
    assign o_valid = (count_reg != {(AW+1){1'b0}});
    assign o_data  = mem_reg[rd_ptr_reg];
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
            for (k = 0; k < DEPTH; k = k + 1) begin
                mem_reg[k] <= {WIDTH{1'b0}};
            end
        end else if (i_flush) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= i_data;
                wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}}
                                                        : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}}
                                                        : rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ===== rtl/scr_regs.v
// Sensor control register bank behind the two-wire serial port.
// Assumes the serial clock and data pin come from outside this clock
// domain, and that motion, rest-level and external register data come
// from logic on i_clk.
`timescale 1ns/100ps
`include "scr_map.vh"
module scr_regs #(
    parameter PULSE_CYC = `SCR_PULSE_CYC,
    parameter IDLE_CYC  = `SCR_IDLE_CYC
) (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_sclk,
    input  wire       i_sdio,
    output reg        o_sdio,
    output reg        o_sdio_oe,
    output reg        o_motion,
    input  wire       i_motion_event,
    input  wire       i_motion_pending,
    output wire       o_illum_off,
    input  wire [1:0] i_rest_level,
    output wire [1:0] o_rest_force,
    output reg  [7:0] o_ext_addr,
    output reg        o_ext_rd_strobe,
    input  wire [7:0] i_ext_rd_data,
    output reg        o_ext_wr_strobe,
    output reg  [7:0] o_ext_wr_data
);
    localparam PH_ADDR  = 2'd0;
    localparam PH_WDATA = 2'd1;
    localparam PH_RDATA = 2'd2;

    reg        sclk_s1_reg;
    reg        sclk_s2_reg;
    reg        sclk_s3_reg;
    reg        sdio_s1_reg;
    reg        sdio_s2_reg;
    reg [1:0]  ph_reg;
    reg [2:0]  bit_reg;
    reg [6:0]  shin_reg;
    reg [6:0]  wr_addr_reg;
    reg [15:0] idle_reg;
    reg        illum_off_reg;
    reg        pin_pol_reg;
    reg        pin_edge_reg;
    reg [7:0]  burst_start_reg;
    reg [7:0]  burst_end_reg;
    reg [1:0]  rest_force_reg;
    reg        prod_active_reg;
    reg [7:0]  prod_addr_reg;
    reg [7:0]  prod_end_reg;
    reg [7:0]  fetch_addr_reg;
    reg        fetch_wait_reg;
    reg        fetch_vld_reg;
    reg [7:0]  fetch_data_reg;
    reg        tx_have_reg;
    reg [7:0]  tx_shift_reg;
    reg [7:0]  pulse_reg;
    reg [7:0]  local_data;
    reg        local_hit;

    wire       sclk_rise;
    wire       sclk_fall;
    wire       abort;
    wire       byte_end;
    wire [7:0] in_byte;
    wire       wr_fire;
    wire       start_fire;
    wire [7:0] start_addr;
    wire       issue;
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire       pop;
    wire       tx_last;
    wire       pin_active;

    assign sclk_rise  = sclk_s2_reg & ~sclk_s3_reg;
    assign sclk_fall  = ~sclk_s2_reg & sclk_s3_reg;
    assign abort      = (idle_reg == IDLE_CYC - 1);
    assign byte_end   = sclk_rise & (bit_reg == 3'd7);
    assign in_byte    = {shin_reg, sdio_s2_reg};
    assign wr_fire    = byte_end & (ph_reg == PH_WDATA);
    assign start_fire = byte_end & (ph_reg == PH_ADDR)
                      & ~shin_reg[`SCR_WRITE_FLAG_BIT - 1];
    assign start_addr = {1'b0, shin_reg[5:0], sdio_s2_reg};
    assign issue      = prod_active_reg & ~fetch_wait_reg & ~fetch_vld_reg;
    assign pop        = fifo_out_valid & ~tx_have_reg;
    assign tx_last    = ~prod_active_reg & ~fetch_wait_reg & ~fetch_vld_reg
                      & ~fifo_out_valid;
    assign pin_active = pin_edge_reg ? (pulse_reg != 8'h00)
                                     : i_motion_pending;
    assign o_illum_off  = illum_off_reg;
    assign o_rest_force = rest_force_reg;

    // Only the second stage of the data synchroniser feeds logic; the clock's second and third stages feed its edge detector.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_s1_reg <= 1'b1;
            sclk_s2_reg <= 1'b1;
            sclk_s3_reg <= 1'b1;
            sdio_s1_reg <= 1'b0;
            sdio_s2_reg <= 1'b0;
        end else begin
            sclk_s1_reg <= i_sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            sdio_s1_reg <= i_sdio;
            sdio_s2_reg <= sdio_s1_reg;
        end
    end

    // A stalled serial clock drops a half-finished frame so the
    // controller can resynchronise by simply waiting.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            idle_reg <= 16'h0000;
        end else if (sclk_rise | sclk_fall | abort) begin
            idle_reg <= 16'h0000;
        end else begin
            idle_reg <= idle_reg + 16'h0001;
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ph_reg      <= PH_ADDR;
            bit_reg     <= 3'd0;
            shin_reg    <= 7'h00;
            wr_addr_reg <= 7'h00;
        end else if (abort) begin
            ph_reg  <= PH_ADDR;
            bit_reg <= 3'd0;
        end else if (sclk_rise) begin
            bit_reg  <= bit_reg + 3'd1;
            shin_reg <= in_byte[6:0];
            if (bit_reg == 3'd7) begin
                case (ph_reg)
                    PH_ADDR: begin
                        wr_addr_reg <= in_byte[6:0];
                        if (in_byte[`SCR_WRITE_FLAG_BIT]) begin
                            ph_reg <= PH_WDATA;
                        end else begin
                            ph_reg <= PH_RDATA;
                        end
                    end
                    PH_WDATA: begin
                        ph_reg <= PH_ADDR;
                    end
                    PH_RDATA: begin
                        if (tx_last) begin
                            ph_reg <= PH_ADDR;
                        end
                    end
                    default: begin
                        ph_reg <= PH_ADDR;
                    end
                endcase
            end
        end
    end

    // Local register writes; only defined bits are stored.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            illum_off_reg   <= `SCR_RST_ILLUM_OFF;
            pin_pol_reg     <= `SCR_RST_PIN_POL;
            pin_edge_reg    <= `SCR_RST_PIN_EDGE;
            burst_start_reg <= `SCR_RST_BURST_START;
            burst_end_reg   <= `SCR_RST_BURST_END;
            rest_force_reg  <= `SCR_RST_REST_FORCE;
        end else if (wr_fire) begin
            case ({1'b0, wr_addr_reg})
                `SCR_ADDR_ILLUM_CTRL: begin
                    illum_off_reg <= in_byte[`SCR_ILLUM_OFF_BIT];
                end
                `SCR_ADDR_MOTION_CFG: begin
                    pin_pol_reg  <= in_byte[`SCR_PIN_POL_BIT];
                    pin_edge_reg <= in_byte[`SCR_PIN_EDGE_BIT];
                end
                `SCR_ADDR_BURST_START: begin
                    burst_start_reg <= in_byte;
                end
                `SCR_ADDR_BURST_END: begin
                    burst_end_reg <= in_byte;
                end
                `SCR_ADDR_REST_CFG: begin
                    rest_force_reg <= in_byte[`SCR_REST_HI:`SCR_REST_LO];
                end
                default: begin
                    rest_force_reg <= rest_force_reg;
                end
            endcase
        end
    end

    always @* begin
        local_hit  = 1'b1;
        local_data = 8'h00;
        case (fetch_addr_reg)
            `SCR_ADDR_ILLUM_CTRL: begin
                local_data[`SCR_ILLUM_OFF_BIT] = illum_off_reg;
            end
            `SCR_ADDR_MOTION_CFG: begin
                local_data[`SCR_PIN_POL_BIT]  = pin_pol_reg;
                local_data[`SCR_PIN_EDGE_BIT] = pin_edge_reg;
            end
            `SCR_ADDR_BURST_START: begin
                local_data = burst_start_reg;
            end
            `SCR_ADDR_BURST_END: begin
                local_data = burst_end_reg;
            end
            `SCR_ADDR_REST_CFG: begin
                local_data[`SCR_REST_HI:`SCR_REST_LO] = i_rest_level;
            end
            `SCR_ADDR_BURST_PORT: begin
                local_data = `SCR_RST_BURST_PORT;
            end
            default: begin
                local_hit = 1'b0;
            end
        endcase
    end

    // Fetch engine: one register in flight, stalls on a full buffer.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prod_active_reg <= 1'b0;
            prod_addr_reg   <= 8'h00;
            prod_end_reg    <= 8'h00;
            fetch_addr_reg  <= 8'h00;
            fetch_wait_reg  <= 1'b0;
            fetch_vld_reg   <= 1'b0;
            fetch_data_reg  <= 8'h00;
        end else if (abort) begin
            prod_active_reg <= 1'b0;
            fetch_wait_reg  <= 1'b0;
            fetch_vld_reg   <= 1'b0;
        end else begin
            if (start_fire) begin
                prod_active_reg <= 1'b1;
                if (start_addr == `SCR_ADDR_BURST_PORT) begin
                    prod_addr_reg <= burst_start_reg;
                    prod_end_reg  <= burst_end_reg;
                end else begin
                    prod_addr_reg <= start_addr;
                    prod_end_reg  <= start_addr;
                end
            end else if (issue) begin
                fetch_addr_reg <= prod_addr_reg;
                fetch_wait_reg <= 1'b1;
                if (prod_addr_reg == prod_end_reg) begin
                    prod_active_reg <= 1'b0;
                end else begin
                    prod_addr_reg <= prod_addr_reg + 8'h01;
                end
            end
            if (fetch_wait_reg) begin
                fetch_wait_reg <= 1'b0;
                fetch_vld_reg  <= 1'b1;
                fetch_data_reg <= local_hit ? local_data : i_ext_rd_data;
            end else if (fetch_vld_reg & fifo_in_ready) begin
                fetch_vld_reg <= 1'b0;
            end
        end
    end

    // External register port for addresses this bank does not hold.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ext_addr      <= 8'h00;
            o_ext_rd_strobe <= 1'b0;
            o_ext_wr_strobe <= 1'b0;
            o_ext_wr_data   <= 8'h00;
        end else begin
            o_ext_rd_strobe <= 1'b0;
            o_ext_wr_strobe <= 1'b0;
            if (wr_fire) begin
                o_ext_addr      <= {1'b0, wr_addr_reg};
                o_ext_wr_data   <= in_byte;
                o_ext_wr_strobe <= ~scr_is_local({1'b0, wr_addr_reg});
            end else if (issue & ~start_fire & ~abort) begin
                o_ext_addr      <= prod_addr_reg;
                o_ext_rd_strobe <= ~scr_is_local(prod_addr_reg);
            end
        end
    end

    scr_fifo #(
        .WIDTH (8),
        .DEPTH (2),
        .AW    (1)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_flush (abort),
        .i_valid (fetch_vld_reg),
        .o_ready (fifo_in_ready),
        .i_data  (fetch_data_reg),
        .o_valid (fifo_out_valid),
        .i_ready (~tx_have_reg),
        .o_data  (fifo_out_data)
    );

    // Serialiser: bits change on falling serial clock, master samples
    // on rising; the pin is released after the last byte's eighth bit.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_have_reg  <= 1'b0;
            tx_shift_reg <= 8'h00;
            o_sdio       <= 1'b0;
            o_sdio_oe    <= 1'b0;
        end else if (abort) begin
            tx_have_reg <= 1'b0;
            o_sdio_oe   <= 1'b0;
        end else if (pop) begin
            tx_have_reg  <= 1'b1;
            tx_shift_reg <= fifo_out_data;
        end else if (sclk_fall & tx_have_reg & (ph_reg == PH_RDATA)) begin
            o_sdio       <= tx_shift_reg[7];
            o_sdio_oe    <= 1'b1;
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end else if (byte_end & (ph_reg == PH_RDATA)) begin
            tx_have_reg <= 1'b0;
            if (tx_last) begin
                o_sdio_oe <= 1'b0;
            end
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pulse_reg <= 8'h00;
            o_motion  <= 1'b1;
        end else begin
            if (pin_edge_reg & i_motion_event) begin
                pulse_reg <= PULSE_CYC[7:0];
            end else if (pulse_reg != 8'h00) begin
                pulse_reg <= pulse_reg - 8'h01;
            end
            o_motion <= pin_pol_reg ? pin_active : ~pin_active;
        end
    end

    function scr_is_local;
        input [7:0] a;
        begin
            scr_is_local = (a == `SCR_ADDR_ILLUM_CTRL)
                         | (a == `SCR_ADDR_MOTION_CFG)
                         | (a == `SCR_ADDR_BURST_START)
                         | (a == `SCR_ADDR_BURST_END)
                         | (a == `SCR_ADDR_REST_CFG)
                         | (a == `SCR_ADDR_BURST_PORT);
        end
    endfunction
endmodule

// ===== test/scr_regs_sva.sv
// Port checker for the sensor control register bank.
// Bound to scr_regs from the testbench file; sees only its ports.
`timescale 1ns/100ps
module scr_regs_sva #(
    parameter PULSE_CYC = 76
) (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_sclk,
    input wire logic       o_sdio,
    input wire logic       o_sdio_oe,
    input wire logic       o_motion,
    input wire logic       i_motion_event,
    input wire logic       o_illum_off,
    input wire logic [1:0] o_rest_force,
    input wire logic [7:0] o_ext_addr,
    input wire logic       o_ext_rd_strobe,
    input wire logic       o_ext_wr_strobe
);
    logic [7:0] since_ev;
    logic       pulse_on;

    default clocking dcb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Age of the last motion event; a pulse that starts with it is timed.
    // The pin answers one edge after the event and that change is sampled
    // one edge later again, so a fresh pulse shows up at age one.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            since_ev <= 8'hFF;
            pulse_on <= 1'b0;
        end else begin
            if (i_motion_event)
                since_ev <= 8'h00;
            else if (since_ev != 8'hFF)
                since_ev <= since_ev + 8'h01;
            if ($changed(o_motion) && since_ev == 8'h01)
                pulse_on <= 1'b1;
            else if (since_ev == PULSE_CYC + 1)
                pulse_on <= 1'b0;
        end
    end

    property p_oe_rise;
        $rose(o_sdio_oe) |-> !$past(i_sclk) && !$past(i_sclk, 2);
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("data drive began outside a low serial phase");
    property p_oe_fall;
        $fell(o_sdio_oe) |-> $past(i_sclk) && $past(i_sclk, 2);
    endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("data drive released outside a high serial phase");
    property p_sdio_hold;
        o_sdio_oe && $past(o_sdio_oe) && $changed(o_sdio)
            |-> !$past(i_sclk, 2);
    endproperty
    a_sdio_hold: assert property (p_sdio_hold)
        else $error("read bit changed during a high serial phase");
    property p_rd_local;
        o_ext_rd_strobe |-> !(o_ext_addr inside {8'h40, 8'h41, 8'h42,
                                                 8'h44, 8'h45, 8'h63});
    endproperty
    a_rd_local: assert property (p_rd_local)
        else $error("local register read sent to external port");
    property p_wr_local;
        o_ext_wr_strobe |-> !(o_ext_addr inside {8'h40, 8'h41, 8'h42,
                                                 8'h44, 8'h45, 8'h63});
    endproperty
    a_wr_local: assert property (p_wr_local)
        else $error("local register write sent to external port");
    property p_illum_sync;
        $changed(o_illum_off) |-> $past(i_sclk, 2) && $past(i_sclk, 3);
    endproperty
    a_illum_sync: assert property (p_illum_sync)
        else $error("illumination control changed without a write");
    property p_rest_sync;
        $changed(o_rest_force) |-> $past(i_sclk, 2) && $past(i_sclk, 3);
    endproperty
    a_rest_sync: assert property (p_rest_sync)
        else $error("rest force changed without a write");
    property p_pulse_hold;
        pulse_on && since_ev > 0 && since_ev <= PULSE_CYC
            |-> $stable(o_motion);
    endproperty
    a_pulse_hold: assert property (p_pulse_hold)
        else $error("motion pulse ended early");
    property p_pulse_end;
        pulse_on && since_ev == PULSE_CYC + 1 |-> $changed(o_motion);
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("motion pulse did not end on time");
endmodule

// ===== test/scr_host_model.sv
// Behavioural mouse controller on the two-wire serial port.
// Assumes the caller spaces frames; the serial clock idles high.
`timescale 1ns/100ps
module scr_host_model (
    input  wire logic i_clk,
    input  wire logic i_sdio_out,
    input  wire logic i_sdio_oe,
    output logic      o_sclk,
    output logic      o_pad
);
    logic       drv_en;
    logic       drv_bit;
    logic       noise;
    logic [7:0] rx [0:15];

    initial begin
        o_sclk = 1'b1;
        drv_en = 1'b0;
        drv_bit = 1'b1;
        noise = 1'b0;
    end
    // A released line carries no held value, so it toggles every cycle.
    always @(posedge i_clk) noise <= ~noise;
    assign o_pad = i_sdio_oe ? i_sdio_out : (drv_en ? drv_bit : noise);

    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            o_sclk = 1'b0;
            drv_en = 1'b1;
            drv_bit = b[i];
            #80;
            o_sclk = 1'b1;
            #80;
        end
    endtask
    task automatic write_reg(input logic [7:0] r, input logic [7:0] x);
        send_byte({1'b1, r[6:0]});
        send_byte(x);
        drv_en = 1'b0;
        #160;
    endtask
    // Exactly the requested byte count is clocked, then the frame ends.
    task automatic read_n(input logic [7:0] r, input int cnt);
        send_byte({1'b0, r[6:0]});
        drv_en = 1'b0;
        for (int j = 0; j < cnt; j++)
            for (int i = 7; i >= 0; i--) begin
                o_sclk = 1'b0;
                #80;
                rx[j][i] = o_pad;
                o_sclk = 1'b1;
                #80;
            end
        #160;
    endtask
endmodule

// ===== test/testbench.sv
// Self-checking bench for the sensor control register bank.
// Assumes the serial controller model and the port checker beside it.
`timescale 1ns/100ps
module testbench;
    localparam logic [7:0] PULSE = 8'h4C;
    // Status, X and Y of the motion core sit at arbitrary external addresses.
    localparam logic [7:0] MV_REG = 8'h30;
    logic       i_clk, i_rst, i_motion_event, i_motion_pending;
    logic [1:0] i_rest_level, frc;
    logic [7:0] i_ext_rd_data, a, d, s;
    wire        sclk, pad, o_sdio, o_sdio_oe, o_motion, o_illum_off;
    wire        o_ext_rd_strobe, o_ext_wr_strobe;
    wire  [1:0] o_rest_force;
    wire  [7:0] o_ext_addr, o_ext_wr_data;
    logic [7:0] ext_mem [0:255];
    logic [7:0] sh [0:255];
    logic [7:0] regs [0:4] = '{8'h40, 8'h41, 8'h42, 8'h44, 8'h45};
    logic [31:0] seed = 32'h34;
    int         err_count, n_tests, cnt, n;

    scr_regs #(.PULSE_CYC(PULSE), .IDLE_CYC(200)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_sdio(pad),
        .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe), .o_motion(o_motion),
        .i_motion_event(i_motion_event), .i_motion_pending(i_motion_pending),
        .o_illum_off(o_illum_off), .i_rest_level(i_rest_level),
        .o_rest_force(o_rest_force), .o_ext_addr(o_ext_addr),
        .o_ext_rd_strobe(o_ext_rd_strobe), .i_ext_rd_data(i_ext_rd_data),
        .o_ext_wr_strobe(o_ext_wr_strobe), .o_ext_wr_data(o_ext_wr_data));
    scr_host_model u_host (.i_clk(i_clk), .i_sdio_out(o_sdio),
        .i_sdio_oe(o_sdio_oe), .o_sclk(sclk), .o_pad(pad));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    always @(negedge i_clk) begin
        if (o_ext_rd_strobe) i_ext_rd_data <= ext_mem[o_ext_addr];
        if (o_ext_wr_strobe) ext_mem[o_ext_addr] <= o_ext_wr_data;
    end

    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] msk(input logic [7:0] r);
        case (r)
            8'h40: return 8'h08;
            8'h41: return 8'hC0;
            8'h42, 8'h44: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] r);
        if (r == 8'h45) return {i_rest_level, 6'h00};
        if (msk(r) != 8'h00) return sh[r];
        return ext_mem[r];
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] x);
        u_host.write_reg(r, x);
        if (msk(r) != 8'h00) sh[r] = x & msk(r);
        if (r == 8'h45) frc = x[7:6];
    endtask
    task automatic burst_chk(input int nb);
        u_host.read_n(8'h63, nb);
        for (int k = 0; k < nb; k++)
            check(u_host.rx[k], exp_rd(sh[8'h42] + k[7:0]));
    endtask
    task automatic complete_run();
        $display("Mismatches %0d of %0d comparisons", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        complete_run();
    end

    initial begin
        i_rst = 1'b1;
        i_motion_event = 1'b0;
        i_motion_pending = 1'b0;
        i_rest_level = 2'h0;
        i_ext_rd_data = 8'h00;
        frc = 2'h0;
        for (int k = 0; k < 256; k++) begin
            ext_mem[k] = rnd8();
            sh[k] = 8'h00;
        end
        sh[8'h41] = 8'h40;
        sh[8'h42] = 8'h03;
        sh[8'h44] = 8'h09;
        repeat (6) @(posedge i_clk);
        @(negedge i_clk) i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        check({7'h00, o_motion}, 8'h01);
        for (int k = 0; k < 5; k++) begin
            u_host.read_n(regs[k], 1);
            check(u_host.rx[0], exp_rd(regs[k]));
        end
        repeat (16) begin
            n = rnd8() % 6;
            a = (n == 5) ? (rnd8() & 8'h1F) + 8'h10 : regs[n];
            d = rnd8();
            @(negedge i_clk) i_rest_level = d[1:0];
            wr(a, d);
            if (n == 5) check(ext_mem[a], d);
            u_host.read_n(a, 1);
            check(u_host.rx[0], exp_rd(a));
            check({7'h00, o_illum_off}, {7'h00, sh[8'h40][3]});
            check({6'h00, o_rest_force}, {6'h00, frc});
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h45, {k[1:0] + 2'h1, 6'h00});
            check({6'h00, o_rest_force}, {6'h00, frc});
        end
        wr(8'h63, 8'hFF);
        u_host.read_n(8'h42, 1);
        check(u_host.rx[0], sh[8'h42]);
        for (int m = 0; m < 4; m++) begin
            wr(8'h41, {m[1:0], 6'h3F});
            repeat (4) @(negedge i_clk);
            check({7'h00, o_motion}, {7'h00, ~m[1]});
            if (m[0]) begin
                i_motion_event = 1'b1;
                @(negedge i_clk) i_motion_event = 1'b0;
                cnt = 0;
                repeat (100) begin
                    @(negedge i_clk);
                    if (o_motion === m[1]) cnt++;
                end
                check(cnt[7:0], PULSE);
            end else begin
                i_motion_pending = 1'b1;
                repeat (2) @(negedge i_clk);
                check({7'h00, o_motion}, {7'h00, m[1]});
                for (int q = 0; q < 3; q++) begin
                    u_host.read_n(MV_REG + q[7:0], 1);
                    check(u_host.rx[0], exp_rd(MV_REG + q[7:0]));
                end
                check({7'h00, o_motion}, {7'h00, m[1]});
                i_motion_pending = 1'b0;
                repeat (2) @(negedge i_clk);
                check({7'h00, o_motion}, {7'h00, ~m[1]});
            end
        end
        wr(8'h42, 8'h03);
        wr(8'h44, 8'h09);
        burst_chk(7);
        for (int k = 0; k < 4; k++) begin
            s = (k == 0) ? 8'h3E : rnd8() & 8'h3F;
            n = (k == 0) ? 8 : 2 + rnd8() % 7;
            wr(8'h42, s);
            wr(8'h44, s + n[7:0] - 8'h01);
            burst_chk(n);
        end
        complete_run();
    end
endmodule

bind scr_regs scr_regs_sva #(.PULSE_CYC(PULSE_CYC)) u_sva (
    .i_clk(i_clk), .i_rst(i_rst), .i_sclk(i_sclk), .o_sdio(o_sdio),
    .o_sdio_oe(o_sdio_oe), .o_motion(o_motion),
    .i_motion_event(i_motion_event), .o_illum_off(o_illum_off),
    .o_rest_force(o_rest_force), .o_ext_addr(o_ext_addr),
    .o_ext_rd_strobe(o_ext_rd_strobe), .o_ext_wr_strobe(o_ext_wr_strobe));
